/* File: bench/sdap_far_model.sv */
// Far-side model: audio processor that clocks the port and captures its data.
// Assumes the bench calls run_frame; the bit clock rests between frames.
`timescale 1ns/1ps
`default_nettype none

module sdap_far_model (
    output logic      audio_bit_clock,
    output logic      audio_frame_sync,
    input  wire logic serial_data_out
);
    logic [0:127] cap;
    int           stray;

    initial begin
        audio_bit_clock  = 1'b1;
        audio_frame_sync = 1'b1;
        cap              = '0;
        stray            = 0;
    end

    // ==========================================================
    // One stereo frame of 2*s slots, 800 ns each
    task automatic run_frame(input logic [1:0] fmt, input logic fall, input int s);
        logic lvl;
        lvl              = (fmt == 2'h0);
        audio_bit_clock  = ~fall;
        audio_frame_sync = lvl;
        // Odd wait keeps link edges off the hclk edges
        #2037;
        for (int k = 0; k < 2 * s; k++) begin
            audio_bit_clock = fall;
            if (k == 0) begin
                audio_frame_sync = (fmt == 2'h2) ? 1'b1 : ~lvl;
            end else if (k == 1 && fmt == 2'h2) begin
                audio_frame_sync = 1'b0;
            end else if (k == s && fmt != 2'h2) begin
                audio_frame_sync = lvl;
            end
            #400;
            audio_bit_clock = ~fall;
            cap[k]          = serial_data_out;
            #350;
            if (serial_data_out !== cap[k]) begin
                stray++;
            end
            #50;
        end
    endtask : run_frame
endmodule : sdap_far_model
`default_nettype wire

/* File: bench/slave_digital_audio_port_bench.sv */
// Self-checking bench of the serial audio port.
// Assumes the far model drives the link and the bench is the only bus master.
`include "sdap_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module slave_digital_audio_port_bench;
    logic        hclk = 1'b0;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    wire logic   hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        bclk;
    logic        fsync;
    logic        sdata;
    logic        sdata_oe;
    logic        analog_en;
    int          failures = 0;
    int          check_count = 0;
    logic [1:0]  t_fmt [7] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2};
    logic        t_fall [7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    logic        t_late [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    logic [1:0]  t_ws [7] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h2, 2'h3};
    int          t_n [7] = '{16, 20, 24, 8, 8, 20, 24};
    // Short frame on row 3 gives about 48 kHz at an 800 ns bit clock
    int          t_s [7] = '{32, 32, 32, 13, 32, 32, 32};

    assign hready = hreadyout;
    always #50 hclk = ~hclk;

    sdap_top u_dut (
        .hclk              (hclk),
        .hresetn           (hresetn),
        .hsel              (hsel),
        .haddr             (haddr),
        .htrans            (htrans),
        .hwrite            (hwrite),
        .hsize             (hsize),
        .hwdata            (hwdata),
        .hready            (hready),
        .hrdata            (hrdata),
        .hreadyout         (hreadyout),
        .hresp             (hresp),
        .audio_bit_clock   (bclk),
        .audio_frame_sync  (fsync),
        .serial_data_out   (sdata),
        .serial_data_oe    (sdata_oe),
        .analog_out_enable (analog_en)
    );

    sdap_far_model u_far (
        .audio_bit_clock  (bclk),
        .audio_frame_sync (fsync),
        .serial_data_out  (sdata)
    );

    // ==========================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // No wait-state count assumed; only the watchdog ends a hung wait
    task automatic wait_ready();
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
    endtask : wait_ready

    task automatic ahb_xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        r = hrdata;
        check({31'h0, hresp}, 32'h0000_0000);
    endtask : ahb_xfer

    function automatic logic [31:0] word(input int st, input int n);
        logic [31:0] w;
        w = '0;
        for (int j = 0; j < n; j++) begin
            w = {w[30:0], u_far.cap[st + j]};
        end
        return w;
    endfunction : word

    // ==========================================================
    // Scenarios
    task automatic test_regs();
        logic [31:0] r;
        ahb_xfer(1'b0, `SDAP_OFF_CTRL, 32'h0, r);
        check(r, `SDAP_CTRL_RESET);
        ahb_xfer(1'b1, 32'h0000_0010, 32'hFFFF_FFFF, r);
        ahb_xfer(1'b0, 32'h0000_0010, 32'h0, r);
        check(r, 32'h0000_0000);
        ahb_xfer(1'b1, `SDAP_OFF_LEFT, 32'hFFFF_FFFF, r);
        ahb_xfer(1'b0, `SDAP_OFF_LEFT, 32'h0, r);
        check(r, 32'h00FF_FFFF);
        for (int m = 0; m < 3; m++) begin
            ahb_xfer(1'b1, `SDAP_OFF_CTRL, (32'(m) << `SDAP_CTRL_MODE_LO) | 32'h0000_0021, r);
            repeat (2) @(posedge hclk);
            check({31'h0, analog_en}, {31'h0, m != 1});
            check({31'h0, sdata_oe}, {31'h0, m != 0});
        end
        $display("register test done");
    endtask : test_regs

    task automatic test_format(input int i);
        logic [31:0] r;
        logic [31:0] ctrl;
        logic [31:0] mask;
        int          off;
        int          ro;
        off  = (t_fmt[i] == 2'h0 || t_late[i]) ? 1 : 0;
        ro   = (t_fmt[i] == 2'h2) ? off + t_n[i] : t_s[i] + off;
        mask = 32'h00FF_FFFF >> (24 - t_n[i]);
        ctrl = 32'h0000_0101 | (32'(t_fmt[i]) << `SDAP_CTRL_FMT_LO) | (32'(t_fall[i]) << `SDAP_CTRL_FALL)
             | (32'(t_late[i]) << `SDAP_CTRL_LATE) | (32'(t_ws[i]) << `SDAP_CTRL_WS_LO);
        ahb_xfer(1'b1, `SDAP_OFF_LEFT, 32'h00C3_A596, r);
        ahb_xfer(1'b1, `SDAP_OFF_RIGHT, 32'h005A_3C69, r);
        ahb_xfer(1'b1, `SDAP_OFF_CTRL, ctrl, r);
        repeat (2) u_far.run_frame(t_fmt[i], t_fall[i], t_s[i]);
        check(word(off, t_n[i]), 32'h00C3_A596 & mask);
        check(word(ro, t_n[i]), 32'h005A_3C69 & mask);
        check({31'h0, u_far.cap[ro + t_n[i]]}, 32'h0000_0000);
        check(32'(u_far.stray), 32'h0000_0000);
        $display("format test %0d done", i);
    endtask : test_format

    task automatic test_disabled();
        logic [31:0] r;
        // Frames ran earlier, sync rests low: taken set, level bit clear
        ahb_xfer(1'b0, `SDAP_OFF_STAT, 32'h0, r);
        check(r & 32'h0000_0003, 32'h0000_0001);
        ahb_xfer(1'b1, `SDAP_OFF_STAT, 32'h0000_0001, r);
        ahb_xfer(1'b0, `SDAP_OFF_STAT, 32'h0, r);
        check(r & 32'h0000_0003, 32'h0000_0000);
        ahb_xfer(1'b1, `SDAP_OFF_CTRL, 32'h0000_0122, r);
        u_far.run_frame(2'h1, 1'b0, 32);
        check(word(0, 32), 32'h0000_0000);
        check(word(32, 32), 32'h0000_0000);
        check({31'h0, sdata_oe}, 32'h0000_0000);
        // A disabled port takes no frame
        ahb_xfer(1'b0, `SDAP_OFF_STAT, 32'h0, r);
        check(r & 32'h0000_0003, 32'h0000_0000);
        $display("disabled test done");
    endtask : test_disabled

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        hresetn = 1'b0;
        hsel    = 1'b0;
        haddr   = 32'h0;
        htrans  = 2'h0;
        hwrite  = 1'b0;
        hsize   = 3'h2;
        hwdata  = 32'h0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        test_regs();
        for (int i = 0; i < 7; i++) begin
            test_format(i);
        end
        test_disabled();
        complete_run();
    end

    initial begin
        #3000000;
        failures++;
        complete_run();
    end
endmodule : slave_digital_audio_port_bench
`default_nettype wire

/* File: design/sdap_consts.svh */
// Offsets, field positions, reset values and word sizes of the serial audio port.
// Assumes inclusion by bare name from the package and the top module.
`ifndef SDAP_CONSTS_SVH
`define SDAP_CONSTS_SVH

// ==========================================================================
// Register map
`define SDAP_ADDR_W        8
`define SDAP_OFF_CTRL      8'h00
`define SDAP_OFF_LEFT      8'h04
`define SDAP_OFF_RIGHT     8'h08
`define SDAP_OFF_STAT      8'h0C

// ==========================================================================
// Control fields
`define SDAP_CTRL_EN       0
`define SDAP_CTRL_FMT_LO   1
`define SDAP_CTRL_FMT_HI   2
`define SDAP_CTRL_FALL     3
`define SDAP_CTRL_LATE     4
`define SDAP_CTRL_WS_LO    5
`define SDAP_CTRL_WS_HI    6
`define SDAP_CTRL_MODE_LO  8
`define SDAP_CTRL_MODE_HI  9
`define SDAP_CTRL_RESET    32'h0000_0120

// ==========================================================================
// Status fields
`define SDAP_STAT_TAKEN    0
`define SDAP_STAT_FS       1
`define SDAP_STAT_CNT_LO   16
`define SDAP_STAT_CNT_HI   31

// ==========================================================================
// Word sizes
`define SDAP_SAMPLE_W      24
`define SDAP_WS_8          5'h08
`define SDAP_WS_16         5'h10
`define SDAP_WS_20         5'h14
`define SDAP_WS_24         5'h18

`endif

/* File: design/sdap_edge_sync.sv */
// Two-flop synchroniser with edge pulses for one external pin.
// Assumes the pin is asynchronous to hclk and slower than hclk / 4.
`timescale 1ns/1ps
`default_nettype none

module sdap_edge_sync (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic pin_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic s1;
    logic s2;
    logic s3;

    // ======================================================================
    // Only s2 reads s1
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= pin_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    always_comb begin
        level = s2;
        rise  = s2 & ~s3;
        fall  = ~s2 & s3;
    end

endmodule : sdap_edge_sync

`default_nettype wire

/* File: design/sdap_pkg.sv */
// Types of the serial audio port.
// Assumes the constants header is on the include path.
`include "sdap_consts.svh"

package sdap_pkg;

    // ======================================================================
    // Framing formats and output modes
    typedef enum logic [1:0] {
        SDAP_FMT_I2S = 2'h0,
        SDAP_FMT_LJ  = 2'h1,
        SDAP_FMT_DSP = 2'h2
    } sdap_fmt_t;

    typedef enum logic [1:0] {
        SDAP_MODE_ANALOG  = 2'h0,
        SDAP_MODE_DIGITAL = 2'h1,
        SDAP_MODE_BOTH    = 2'h2
    } sdap_mode_t;

    function automatic logic [4:0] sdap_word_bits(input logic [1:0] code);
        case (code)
            2'h0:    sdap_word_bits = `SDAP_WS_8;
            2'h1:    sdap_word_bits = `SDAP_WS_16;
            2'h2:    sdap_word_bits = `SDAP_WS_20;
            default: sdap_word_bits = `SDAP_WS_24;
        endcase
    endfunction : sdap_word_bits

endpackage : sdap_pkg

/* File: design/sdap_top.sv */
// Slave serial audio output port with an AHB-Lite register slave.
// Assumes an external processor supplies bit clock and frame sync, both slow against hclk.
//
// How it works
// - Bit clock and frame sync are inputs only
// - I2S MSB on second sample edge
// - I2S left while sync low, right high
// - Left-justified MSB on first sample edge
// - Left-justified left while sync high
// - Pulse format right follows left immediately
// - Pulse format MSB first or second edge
// - Idle bits past word size drive zero
// - Sampling edge selectable, launch follows it
// - Word length 8, 16, 20 or 24
// - Rates 32, 44.1, 48 kHz accepted
// - Digital pins used in digital modes
`include "sdap_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module sdap_top #(
    parameter int unsigned POS_W = 7
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        audio_bit_clock,
    input  wire logic        audio_frame_sync,
    output logic             serial_data_out,
    output logic             serial_data_oe,
    output logic             analog_out_enable
);
    // ======================================================================
    // Pin synchronisers
    logic bclk_rise;
    logic bclk_fall;
    logic fs_lvl;

    // No drivers exist for these pins; only sampling
    sdap_edge_sync u_bclk (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin_in  (audio_bit_clock),
        .level   (),
        .rise    (bclk_rise),
        .fall    (bclk_fall)
    );

    sdap_edge_sync u_fs (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin_in  (audio_frame_sync),
        .level   (fs_lvl),
        .rise    (),
        .fall    ()
    );

    // ======================================================================
    // Registers
    logic                     ctrl_en;
    sdap_pkg::sdap_fmt_t      ctrl_fmt;
    logic                     ctrl_fall;
    logic                     ctrl_late;
    logic [1:0]               ctrl_ws;
    sdap_pkg::sdap_mode_t     ctrl_mode;
    logic [`SDAP_SAMPLE_W-1:0] left;
    logic [`SDAP_SAMPLE_W-1:0] right;
    logic                     taken;
    logic [15:0]              frame_cnt;
    logic                     wr_pend;
    logic [`SDAP_ADDR_W-1:0]  wr_addr;
    logic                     addr_ok;
    logic [31:0]              rd_word;
    logic [31:0]              ctrl_word;
    logic [`SDAP_ADDR_W-1:0]  a_now;

    always_comb begin
        addr_ok = hsel && hready && htrans[1];
        a_now   = haddr[`SDAP_ADDR_W-1:0];
        ctrl_word = 32'h0000_0000;
        ctrl_word[`SDAP_CTRL_EN]                          = ctrl_en;
        ctrl_word[`SDAP_CTRL_FMT_HI:`SDAP_CTRL_FMT_LO]    = ctrl_fmt;
        ctrl_word[`SDAP_CTRL_FALL]                        = ctrl_fall;
        ctrl_word[`SDAP_CTRL_LATE]                        = ctrl_late;
        ctrl_word[`SDAP_CTRL_WS_HI:`SDAP_CTRL_WS_LO]      = ctrl_ws;
        ctrl_word[`SDAP_CTRL_MODE_HI:`SDAP_CTRL_MODE_LO]  = ctrl_mode;
        case (a_now)
            `SDAP_OFF_CTRL:  rd_word = ctrl_word;
            `SDAP_OFF_LEFT:  rd_word = {8'h00, left};
            `SDAP_OFF_RIGHT: rd_word = {8'h00, right};
            `SDAP_OFF_STAT:  rd_word = {frame_cnt, 14'h0000, fs_lvl, taken};
            default:         rd_word = 32'h0000_0000;
        endcase
    end

    // ======================================================================
    // AHB-Lite slave, zero wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend   <= 1'b0;
            wr_addr   <= 8'h00;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            wr_pend   <= addr_ok && hwrite;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (addr_ok) begin
                wr_addr <= a_now;
            end
        end
    end

    // Forward a pending write, except to STAT, so back-to-back write-read sees new data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            if (wr_pend && wr_addr == a_now && a_now != `SDAP_OFF_STAT) begin
                hrdata <= (a_now == `SDAP_OFF_CTRL) ? (hwdata & 32'h0000_037F) : {8'h00, hwdata[23:0]};
            end else begin
                hrdata <= rd_word;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_en   <= 1'b0;
            ctrl_fmt  <= sdap_pkg::sdap_fmt_t'(2'h0);
            ctrl_fall <= 1'b0;
            ctrl_late <= 1'b0;
            ctrl_ws   <= 2'h1;
            ctrl_mode <= sdap_pkg::SDAP_MODE_DIGITAL;
            left      <= 24'h00_0000;
            right     <= 24'h00_0000;
        end else if (wr_pend) begin
            case (wr_addr)
                `SDAP_OFF_CTRL: begin
                    ctrl_en   <= hwdata[`SDAP_CTRL_EN];
                    ctrl_fmt  <= sdap_pkg::sdap_fmt_t'(hwdata[`SDAP_CTRL_FMT_HI:`SDAP_CTRL_FMT_LO]);
                    ctrl_fall <= hwdata[`SDAP_CTRL_FALL];
                    ctrl_late <= hwdata[`SDAP_CTRL_LATE];
                    ctrl_ws   <= hwdata[`SDAP_CTRL_WS_HI:`SDAP_CTRL_WS_LO];
                    ctrl_mode <= sdap_pkg::sdap_mode_t'(hwdata[`SDAP_CTRL_MODE_HI:`SDAP_CTRL_MODE_LO]);
                end
                `SDAP_OFF_LEFT:  left  <= hwdata[`SDAP_SAMPLE_W-1:0];
                `SDAP_OFF_RIGHT: right <= hwdata[`SDAP_SAMPLE_W-1:0];
                default: ;
            endcase
        end
    end

    // ======================================================================
    // Serializer
    logic                      launch;
    logic                      dig_en;
    logic                      fs_last;
    logic                      slot_start;
    logic                      frame_start;
    logic [POS_W-1:0]          pos;
    logic [POS_W-1:0]          next_pos;
    logic [POS_W-1:0]          off;
    logic [POS_W-1:0]          idx;
    logic [POS_W-1:0]          bidx;
    logic [POS_W-1:0]          sel;
    logic [POS_W-1:0]          wbits;
    logic                      in_right;
    logic                      valid;
    logic                      next_bit;
    logic [`SDAP_SAMPLE_W-1:0] lat_l;
    logic [`SDAP_SAMPLE_W-1:0] lat_r;
    logic [`SDAP_SAMPLE_W-1:0] cur_l;
    logic [`SDAP_SAMPLE_W-1:0] cur_r;

    always_comb begin
        // Only edges are counted, no rate is assumed
        launch = ctrl_fall ? bclk_rise : bclk_fall;
        dig_en = ctrl_en && (ctrl_mode == sdap_pkg::SDAP_MODE_DIGITAL
                             || ctrl_mode == sdap_pkg::SDAP_MODE_BOTH);
        wbits  = POS_W'(sdap_pkg::sdap_word_bits(ctrl_ws));
        case (ctrl_fmt)
            sdap_pkg::SDAP_FMT_I2S: begin
                frame_start = (fs_lvl != fs_last) && !fs_lvl;
                slot_start  = fs_lvl != fs_last;
                off         = POS_W'(1);
                in_right    = fs_lvl;
            end
            sdap_pkg::SDAP_FMT_LJ: begin
                frame_start = (fs_lvl != fs_last) && fs_lvl;
                slot_start  = fs_lvl != fs_last;
                off         = POS_W'(0);
                in_right    = !fs_lvl;
            end
            default: begin
                // Pulse start only; its width is the sender's business
                frame_start = fs_lvl && !fs_last;
                slot_start  = frame_start;
                off         = POS_W'(ctrl_late);
                in_right    = 1'b0;
            end
        endcase
        next_pos = slot_start ? '0 : ((&pos) ? pos : pos + POS_W'(1));
        idx      = next_pos - off;
        bidx     = idx;
        if (ctrl_fmt == sdap_pkg::SDAP_FMT_DSP && idx >= wbits) begin
            in_right = 1'b1;
            bidx     = idx - wbits;
        end
        valid    = (next_pos >= off) && (bidx < wbits);
        sel      = wbits - POS_W'(1) - bidx;
        cur_l    = frame_start ? left : lat_l;
        cur_r    = frame_start ? right : lat_r;
        next_bit = valid && (in_right ? cur_r[sel[4:0]] : cur_l[sel[4:0]]);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pos     <= '1;
            fs_last <= 1'b0;
            lat_l   <= 24'h00_0000;
            lat_r   <= 24'h00_0000;
        end else if (launch) begin
            pos     <= next_pos;
            fs_last <= fs_lvl;
            lat_l   <= cur_l;
            lat_r   <= cur_r;
        end
    end

    // While dig_en is set, output only moves on the launch edge; without it output is forced to zero at once
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serial_data_out   <= 1'b0;
            serial_data_oe    <= 1'b0;
            analog_out_enable <= 1'b0;
        end else begin
            serial_data_oe    <= dig_en;
            analog_out_enable <= ctrl_mode != sdap_pkg::SDAP_MODE_DIGITAL;
            if (!dig_en) begin
                serial_data_out <= 1'b0;
            end else if (launch) begin
                serial_data_out <= next_bit;
            end
        end
    end

    // Set wins over a same-cycle clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            taken     <= 1'b0;
            frame_cnt <= 16'h0000;
        end else begin
            if (launch && frame_start && dig_en) begin
                taken     <= 1'b1;
                frame_cnt <= frame_cnt + 16'h0001;
            end else if (wr_pend && wr_addr == `SDAP_OFF_STAT && hwdata[`SDAP_STAT_TAKEN]) begin
                taken <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Assertions
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_OE_MODE: assert property (serial_data_oe |-> $past(dig_en))
        else $error("data driven outside digital mode");
    AST_I2S_MSB: assert property (launch && dig_en && ctrl_fmt == sdap_pkg::SDAP_FMT_I2S
        && next_pos == POS_W'(1) |=> serial_data_out == (fs_lvl ? lat_r[wbits-1] : lat_l[wbits-1]))
        else $error("I2S MSB misplaced");
    AST_I2S_CHAN: assert property (launch && ctrl_fmt == sdap_pkg::SDAP_FMT_I2S
        && slot_start && !fs_lvl |-> frame_start && !in_right)
        else $error("I2S left not on low sync");
    AST_LJ_MSB: assert property (launch && dig_en && ctrl_fmt == sdap_pkg::SDAP_FMT_LJ
        && slot_start |=> serial_data_out == (fs_lvl ? left[wbits-1] : lat_r[wbits-1]))
        else $error("left-justified MSB misplaced");
    AST_LJ_CHAN: assert property (launch && ctrl_fmt == sdap_pkg::SDAP_FMT_LJ
        && slot_start |-> (frame_start == fs_lvl) && (in_right == !fs_lvl))
        else $error("left-justified channel wrong");
    AST_DSP_RIGHT: assert property (launch && dig_en && ctrl_fmt == sdap_pkg::SDAP_FMT_DSP
        && next_pos == off + wbits |=> serial_data_out == lat_r[wbits-1])
        else $error("right word not adjacent");
    AST_DSP_LATE: assert property (launch && dig_en && ctrl_fmt == sdap_pkg::SDAP_FMT_DSP
        && next_pos == POS_W'(ctrl_late) |=> serial_data_out == lat_l[wbits-1])
        else $error("pulse format MSB edge wrong");
    AST_IDLE_ZERO: assert property (launch && dig_en && !valid |=> !serial_data_out)
        else $error("idle bit not zero");
    AST_LAST_BIT: assert property (launch && dig_en && valid && bidx == wbits - POS_W'(1)
        |=> serial_data_out == $past(next_bit) ##1 !launch)
        else $error("word length wrong");
    AST_STABLE: assert property ($changed(serial_data_out) && $past(dig_en)
        |-> $past(launch))
        else $error("data moved off launch edge");
    AST_EDGE_SEL: assert property (launch |-> (ctrl_fall ? bclk_rise : bclk_fall)
        && !(bclk_rise && bclk_fall))
        else $error("launch on sampling edge");

    COV_I2S: cover property (launch && dig_en && frame_start && ctrl_fmt == sdap_pkg::SDAP_FMT_I2S);
    COV_LJ: cover property (launch && dig_en && frame_start && ctrl_fmt == sdap_pkg::SDAP_FMT_LJ);
    COV_DSP: cover property (launch && dig_en && in_right && ctrl_fmt == sdap_pkg::SDAP_FMT_DSP);
    COV_CLR: cover property (wr_pend && wr_addr == `SDAP_OFF_STAT && taken);

endmodule : sdap_top

`default_nettype wire
